// ### tb/fuse_prog_props.sv
`timescale 1ns/1ns
// cause and timing checks at the programming port
module fuse_prog_props #(
    parameter logic [31:0] CAL_BYTES = 32'h80808080
) (
    input wire logic i_mclk, i_rst_b,
    input wire fuse_prog_pkg::prog_pins_type i_pins,
    input wire fuse_prog_pkg::ser_fuse_type i_ser_fuse,
    input wire logic [7:0] o_ser_fuse_read, o_fuse_high_act, o_fuse_low_act,
    input wire logic [7:0] o_rc_osc_trim_register,
    input wire logic o_data_oe, o_ready_busy_out, o_prog_mode,
    input wire logic i_self_program_store_instr, i_store_target_boot,
    input wire logic i_program_memory_load_instr, i_load_from_app, i_load_target_boot,
    input wire logic i_exec_in_boot, i_ivec_in_app,
    input wire logic o_store_deny, o_load_deny, o_irq_disable
);
    import fuse_prog_pkg::*;
    logic [15:0] busy_cnt_r;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // cycles spent with ready low
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b || o_ready_busy_out)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    sequence s_oe_idle;
        i_pins.oe_b [*3];
    endsequence
    sequence s_busy_end;
        $rose(o_ready_busy_out);
    endsequence
    a_oe_needs_mode: assert property (o_data_oe |-> o_prog_mode)
        else $error("bus driven outside mode");
    a_oe_released: assert property (s_oe_idle |-> !o_data_oe)
        else $error("bus driven while oe high");
    a_oe_follows: assert property ((o_prog_mode && !i_pins.oe_b) [*3] |-> o_data_oe)
        else $error("bus not driven during read");
    a_busy_length: assert property (s_busy_end |->
        busy_cnt_r == WRITE_CYC || busy_cnt_r == ERASE_CYC) else $error("busy length");
    a_store_cause: assert property (!(i_self_program_store_instr &&
        i_store_target_boot) |=> !o_store_deny) else $error("store deny uncaused");
    a_load_cause: assert property (!(i_program_memory_load_instr &&
        i_load_from_app && i_load_target_boot) |=> !o_load_deny) else $error("load deny");
    a_irq_cause: assert property (!(i_exec_in_boot && i_ivec_in_app)
        |=> !o_irq_disable) else $error("irq disable uncaused");
    a_fuse_held: assert property (o_prog_mode [*3] |->
        $stable(o_fuse_high_act) && $stable(o_fuse_low_act)) else $error("fuse moved");
    a_trim_reset: assert property ($rose(i_rst_b) |->
        o_rc_osc_trim_register == CAL_BYTES[7:0] && o_ready_busy_out) else $error("trim");
    a_serial_prog_enable_fuse_hidden: assert property (i_ser_fuse.hi_sel [*2] |-> o_ser_fuse_read[5])
        else $error("serial enable visible");
endmodule // fuse_prog_props
bind fuse_prog_port fuse_prog_props #(.CAL_BYTES(CAL_BYTES)) u_fuse_prog_props (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_pins(i_pins), .i_ser_fuse(i_ser_fuse),
    .o_ser_fuse_read(o_ser_fuse_read), .o_fuse_high_act(o_fuse_high_act),
    .o_fuse_low_act(o_fuse_low_act), .o_rc_osc_trim_register(o_rc_osc_trim_register),
    .o_data_oe(o_data_oe), .o_ready_busy_out(o_ready_busy_out), .o_prog_mode(o_prog_mode),
    .i_self_program_store_instr(i_self_program_store_instr),
    .i_store_target_boot(i_store_target_boot),
    .i_program_memory_load_instr(i_program_memory_load_instr),
    .i_load_from_app(i_load_from_app), .i_load_target_boot(i_load_target_boot),
    .i_exec_in_boot(i_exec_in_boot), .i_ivec_in_app(i_ivec_in_app),
    .o_store_deny(o_store_deny), .o_load_deny(o_load_deny), .o_irq_disable(o_irq_disable));

// ### tb/prog_model.sv
`timescale 1ns/1ns
// parallel programmer on the far side of the port
module prog_model (
    input wire logic i_mclk,
    input wire logic i_data_oe,
    input wire logic i_ready,
    input wire logic [7:0] i_rd,
    output fuse_prog_pkg::prog_pins_type o_pins,
    output logic [7:0] o_data
);
    import fuse_prog_pkg::*;
    logic [7:0] drv_r = 8'h00;
    initial o_pins = 9'h060; // oe_b and wr_b idle high
    // bus shows the inverse while the port drives it, no pull on it
    assign o_data = i_data_oe ? ~drv_r : drv_r;
    task automatic hold();
        repeat (5) @(negedge i_mclk);
    endtask
    // action set up before the crystal pulse
    task automatic xtal(input logic [1:0] a, input logic b1, input logic [7:0] d);
        {o_pins.action_select_1, o_pins.action_select_0} = a;
        o_pins.byte_select_one = b1;
        drv_r = d;
        hold();
        o_pins.crystal_input_pin = 1'b1;
        hold();
        o_pins.crystal_input_pin = 1'b0;
        hold();
    endtask
    // write strobe, counting busy cycles
    task automatic wr(input logic b1, output int lows);
        o_pins.byte_select_one = b1;
        hold();
        o_pins.wr_b = 1'b0;
        lows = 0;
        for (int i = 0; i < 310; i++) begin
            @(negedge i_mclk);
            if (i == 5)
                o_pins.wr_b = 1'b1;
            if (!i_ready)
                lows++;
        end
    endtask
    task automatic rd(input logic b2, input logic b1, output logic [7:0] d);
        o_pins.byte_select_two = b2;
        o_pins.byte_select_one = b1;
        hold();
        o_pins.oe_b = 1'b0;
        hold();
        d = i_rd;
        o_pins.oe_b = 1'b1;
        hold();
    endtask
    task automatic page();
        o_pins.page_latch_strobe = 1'b1;
        hold();
        o_pins.page_latch_strobe = 1'b0;
        hold();
    endtask
    // entry pins low, then high voltage level
    task automatic mode(input logic on);
        {o_pins.page_latch_strobe, o_pins.action_select_1} = 2'b00;
        {o_pins.action_select_0, o_pins.byte_select_one} = 2'b00;
        hold();
        o_pins.hv_entry = on;
        hold();
    endtask
endmodule // prog_model

// ### tb/tb_top.sv
`timescale 1ns/1ns
// bench for the fuse and programming port
module tb_top;
    import fuse_prog_pkg::*;
    localparam logic [31:0] CAL = 32'h84838281;
    localparam logic [23:0] SIG = 24'h3C2B1A; // arbitrary identity values
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    prog_pins_type pins;
    ser_fuse_type ser = '0;
    logic [7:0] bus, rd, fh, fl, trim, sr, v;
    logic oe, rdy, pm, pres;
    logic [2:0] den;
    logic [6:0] req = '0;
    logic [1:0] mb;
    logic trim_wr = 1'b0;
    logic [7:0] trim_d = 8'h00;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int lows;
    fuse_prog_port #(.SIG_BYTE0(SIG[7:0]), .SIG_BYTE1(SIG[15:8]), .SIG_BYTE2(SIG[23:16]),
        .CAL_BYTES(CAL), .PAGE_WORDS(32)) u_fuse_prog_port (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_pins(pins), .i_data(bus), .o_data(rd),
        .o_data_oe(oe), .o_ready_busy_out(rdy), .o_prog_mode(pm), .i_ser_fuse(ser),
        .o_ser_fuse_read(sr), .o_fuse_high_act(fh), .o_fuse_low_act(fl),
        .o_eeprom_preserve_eff(pres), .i_self_program_store_instr(req[6]),
        .i_store_target_boot(req[5]), .i_program_memory_load_instr(req[4]),
        .i_load_from_app(req[3]), .i_load_target_boot(req[2]), .i_exec_in_boot(req[1]),
        .i_ivec_in_app(req[0]), .o_store_deny(den[2]), .o_load_deny(den[1]),
        .o_irq_disable(den[0]), .i_trim_wr(trim_wr), .i_trim_data(trim_d),
        .o_rc_osc_trim_register(trim));
    prog_model u_prog_model (.i_mclk(i_mclk), .i_data_oe(oe), .i_ready(rdy), .i_rd(rd),
        .o_pins(pins), .o_data(bus));
    initial forever #20 i_mclk = ~i_mclk;
    task automatic final_report();
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // command, low address, then a read
    task automatic get(input logic [7:0] c, input logic [7:0] a, input logic [1:0] bs);
        u_prog_model.xtal(2'b10, 1'b0, c);
        u_prog_model.xtal(2'b00, 1'b0, a);
        u_prog_model.rd(bs[1], bs[0], v);
    endtask
    // command, low data byte, then write strobe with the byte select
    task automatic put(input logic [7:0] c, input logic [7:0] d, input logic b1);
        u_prog_model.xtal(2'b10, 1'b0, c);
        u_prog_model.xtal(2'b01, 1'b0, d);
        u_prog_model.wr(b1, lows);
    endtask
    // cycle ceiling against a hang
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(negedge i_mclk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_mclk);
        chk("fuse high", 8'hD9, fh);
        chk("fuse low", 8'hE1, fl);
        chk("trim", CAL[7:0], trim);
        chk("preserve", 8'h01, {7'h00, pres});
        // serial try at the serial enable fuse
        ser = {1'b1, 1'b1, 8'hF9};
        @(negedge i_mclk);
        ser.wr = 1'b0;
        @(negedge i_mclk);
        chk("serial read", 8'hF9, sr);
        u_prog_model.mode(1'b1);
        chk("mode", 8'h01, {7'h00, pm});
        get(8'h04, 8'h00, 2'b11);
        chk("serial fuse", 8'hD9, v);
        for (int i = 0; i < 4; i++) begin
            get(8'h08, 8'(i), 2'b00);
            chk("signature", (i < 3) ? SIG[8*i+:8] : 8'hFF, v);
            get(8'h08, 8'(i), 2'b01);
            chk("calibration", CAL[8*i+:8], v);
        end
        // a nonzero high address is outside the signature row
        u_prog_model.xtal(2'b00, 1'b0, 8'h00);
        u_prog_model.xtal(2'b00, 1'b1, 8'h01);
        u_prog_model.rd(1'b0, 1'b0, v);
        chk("signature window", 8'hFF, v);
        u_prog_model.xtal(2'b00, 1'b1, 8'h00);
        // page word through both bytes, idle code before the page strobe
        u_prog_model.xtal(2'b10, 1'b0, 8'h10);
        u_prog_model.xtal(2'b00, 1'b0, 8'h03);
        u_prog_model.xtal(2'b01, 1'b0, 8'h34);
        u_prog_model.xtal(2'b01, 1'b1, 8'h12);
        u_prog_model.xtal(2'b11, 1'b1, 8'h77);
        u_prog_model.page();
        get(8'h02, 8'h03, 2'b00);
        chk("flash low", 8'h34, v);
        get(8'h02, 8'h03, 2'b01);
        chk("flash high", 8'h12, v);
        put(8'h40, 8'hD1, 1'b1);
        chk("busy", WRITE_CYC[7:0], lows[7:0]);
        chk("preserve", 8'h00, {7'h00, pres});
        chk("latched", 8'hD9, fh);
        put(8'h40, 8'hE2, 1'b0);
        put(8'h20, 8'h3E, 1'b0);
        put(8'h40, 8'hFF, 1'b1);
        chk("refused", 8'h00, lows[7:0]);
        get(8'h04, 8'h00, 2'b11);
        chk("high", 8'hD1, v);
        get(8'h04, 8'h00, 2'b00);
        chk("low", 8'hE2, v);
        get(8'h04, 8'h00, 2'b01);
        chk("lock", 8'hFE, v);
        u_prog_model.mode(1'b0);
        chk("active", 8'hD1, fh);
        // each boot lock mode after an erase
        for (int m = 0; m < 4; m++) begin
            mb = 2'(m);
            u_prog_model.mode(1'b1);
            put(8'h80, 8'hFF, 1'b0);
            chk("erase", ERASE_CYC[7:0], lows[7:0]);
            put(8'h20, {2'b11, mb, 4'hF}, 1'b0);
            u_prog_model.mode(1'b0);
            chk("erase fuse", 8'hE2, fl);
            req = '1;
            repeat (3) @(negedge i_mclk);
            chk("deny", {5'h00, ~mb[0], ~mb[1], ~mb[1]}, {5'h00, den});
            req = '0;
        end
        // software reload of the trim, then a second reset restores the 1 MHz value
        trim_d = CAL[31:24];
        trim_wr = 1'b1;
        @(negedge i_mclk);
        trim_wr = 1'b0;
        @(negedge i_mclk);
        chk("trim load", CAL[31:24], trim);
        i_rst_b = 1'b0;
        repeat (5) @(negedge i_mclk);
        i_rst_b = 1'b1;
        repeat (2) @(negedge i_mclk);
        chk("trim reset", CAL[7:0], trim);
        chk("fuse power-up", 8'hD9, fh);
        final_report();
    end
endmodule // tb_top

// ### verilog/fuse_prog_pkg.sv
package fuse_prog_pkg;
    // fuse and lock reset values, programmed bit reads 0
    localparam logic [7:0] FUSE_HIGH_RST = 8'hD9;
    localparam logic [7:0] FUSE_LOW_RST = 8'hE1;
    localparam logic [5:0] LOCK_RST = 6'h3F;
    // bit positions
    localparam int FH_SERIAL_PROG_ENABLE_FUSE = 5;
    localparam int FH_EEPROM_PRESERVE_FUSE = 3;
    localparam int LK_LB1 = 0;
    localparam int LK_BOOT_LOCK_LOWER = 4;
    localparam int LK_BOOT_LOCK_UPPER = 5;
    // action select codes on crystal pulse
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    // command bytes
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int T_WRITE_NS = 4500;
    localparam int T_ERASE_NS = 9000;
    localparam logic [15:0] WRITE_CYC = 16'((T_WRITE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] ERASE_CYC = 16'((T_ERASE_NS * CLK_MHZ + 999) / 1000);
    // programming port pins, all asynchronous to i_mclk
    typedef struct packed {
        logic hv_entry;
        logic crystal_input_pin;
        logic oe_b;
        logic wr_b;
        logic page_latch_strobe;
        logic action_select_1;
        logic action_select_0;
        logic byte_select_one;
        logic byte_select_two;
    } prog_pins_type;
    // serial path fuse access
    typedef struct packed {
        logic wr;
        logic hi_sel;
        logic [7:0] data;
    } ser_fuse_type;
endpackage

// ### verilog/fuse_prog_port.sv
//Contract
// - boot lock 11: no store or load restriction
// - boot lock 10: stores into boot blocked
// - boot lock 00 blocks both; 01 blocks reads
// - read-block modes mask interrupts in boot code
// - high fuse byte layout, default D9
// - low fuse byte layout, default E1
// - serial path cannot read or change serial_prog_enable_fuse
// - chip erase leaves fuses unchanged
// - fuse writes refused while lock bit one programmed
// - fuses latched at entry and power-up
// - eeprom preserve fuse acts at once
// - three signature bytes readable despite locks
// - four oscillator trim values in signature row
// - reset loads 1 MHz trim value
// - crystal pulse performs action select operation
// - write or output enable runs loaded command
// - ready busy low while operation runs
// - data bus driven only while oe low
// - byte selects pick low or high bytes
// - page latch strobe stores data into buffer
// - action codes: address, data, command, idle
// - command byte decode table
`timescale 1ns/1ns
module fuse_prog_port #(
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'hA5, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary identity value
    parameter logic [31:0] CAL_BYTES = 32'h80808080, // 8,4,2,1 MHz trims
    parameter int PAGE_WORDS = 32
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire fuse_prog_pkg::prog_pins_type i_pins,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_ready_busy_out,
    output logic o_prog_mode,
    input wire fuse_prog_pkg::ser_fuse_type i_ser_fuse,
    output logic [7:0] o_ser_fuse_read,
    output logic [7:0] o_fuse_high_act,
    output logic [7:0] o_fuse_low_act,
    output logic o_eeprom_preserve_eff,
    input wire logic i_self_program_store_instr,
    input wire logic i_store_target_boot,
    input wire logic i_program_memory_load_instr,
    input wire logic i_load_from_app,
    input wire logic i_load_target_boot,
    input wire logic i_exec_in_boot,
    input wire logic i_ivec_in_app,
    output logic o_store_deny,
    output logic o_load_deny,
    output logic o_irq_disable,
    input wire logic i_trim_wr,
    input wire logic [7:0] i_trim_data,
    output logic [7:0] o_rc_osc_trim_register
);
    import fuse_prog_pkg::*;

    localparam int PW_BITS = $clog2(PAGE_WORDS);
    // synchroniser and history reset to the idle pin levels, oe_b and wr_b high
    localparam prog_pins_type PINS_IDLE = 9'h060;

    // page buffer index must cover the whole buffer
    initial begin
        if (PAGE_WORDS < 2 || PAGE_WORDS > 256) $error("page words out of range");
        if ((PAGE_WORDS & (PAGE_WORDS - 1)) != 0) $error("page words not a power of two");
    end

    // busy sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} state_type;

    // port registers and page buffer
    prog_pins_type pins_q, pins_d_r;
    logic [7:0] data_q;
    state_type state_r, state_nxt;
    logic [15:0] busy_cnt_r;
    logic [7:0] cmd_r, addr_lo_r, addr_hi_r, data_lo_r, data_hi_r;
    logic [7:0] fuse_high_r, fuse_low_r;
    logic [5:0] lock_r;
    logic [7:0] rd_data_r, rd_mux;
    logic prog_mode_r;
    logic [15:0] page_buf [PAGE_WORDS];

    // pin synchronisers
    pin_sync #(.WIDTH($bits(prog_pins_type))) u_pin_sync (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_d(i_pins),
        .i_rst_val(PINS_IDLE),
        .o_q(pins_q)
    );
    pin_sync #(.WIDTH(8)) u_data_sync (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_d(i_data),
        .i_rst_val('1),
        .o_q(data_q)
    );

    // edge detection on synchronised pins
    wire xtal_rise = pins_q.crystal_input_pin & ~pins_d_r.crystal_input_pin;
    wire wr_fall = ~pins_q.wr_b & pins_d_r.wr_b;
    wire page_latch_strobe_rise = pins_q.page_latch_strobe & ~pins_d_r.page_latch_strobe;
    // entry and exit on the high-voltage level
    wire hv_rise = pins_q.hv_entry & ~pins_d_r.hv_entry;
    wire hv_fall = ~pins_q.hv_entry & pins_d_r.hv_entry;
    wire [3:0] prog_en = {pins_q.page_latch_strobe, pins_q.action_select_1,
                          pins_q.action_select_0, pins_q.byte_select_one};
    wire enter_prog = hv_rise & (prog_en == 4'h0);
    wire leave_prog = prog_mode_r & hv_fall;
    // action and byte selects
    wire [1:0] act = {pins_q.action_select_1, pins_q.action_select_0};
    wire idle = (state_r == ST_IDLE);
    wire bs1 = pins_q.byte_select_one;
    wire bs2 = pins_q.byte_select_two;
    wire oe_on = prog_mode_r & ~pins_q.oe_b;

    // command decode on write strobe
    wire run_cmd = prog_mode_r & idle & wr_fall;
    wire fuse_locked = ~lock_r[LK_LB1];
    wire do_erase = run_cmd & (cmd_r == CMD_ERASE);
    wire do_wr_fuse = run_cmd & (cmd_r == CMD_WR_FUSE) & ~fuse_locked;
    wire do_wr_lock = run_cmd & (cmd_r == CMD_WR_LOCK);
    wire do_wr_page = run_cmd & ((cmd_r == CMD_WR_FLASH) | (cmd_r == CMD_WR_EEPROM));
    wire start_busy = do_erase | do_wr_fuse | do_wr_lock | do_wr_page;
    // busy length and page word index
    wire [15:0] busy_load = do_erase ? ERASE_CYC : WRITE_CYC;
    wire [PW_BITS-1:0] word_idx = addr_lo_r[PW_BITS-1:0];

    // serial path fuse write, serial_prog_enable_fuse kept out of its reach
    wire ser_fuse_ok = i_ser_fuse.wr & ~fuse_locked & ~prog_mode_r;
    wire [7:0] ser_high_val = {i_ser_fuse.data[7:6], fuse_high_r[FH_SERIAL_PROG_ENABLE_FUSE],
                               i_ser_fuse.data[4:0]};

    // read data selection
    wire sig_hit = (addr_hi_r == 8'h00) & (addr_lo_r[7:2] == 6'h00);
    wire [7:0] sig_byte = !sig_hit ? 8'hFF : (addr_lo_r[1:0] == 2'h0) ? SIG_BYTE0 :
                          (addr_lo_r[1:0] == 2'h1) ? SIG_BYTE1 :
                          (addr_lo_r[1:0] == 2'h2) ? SIG_BYTE2 : 8'hFF;
    wire [7:0] cal_byte = CAL_BYTES[{addr_lo_r[1:0], 3'h0} +: 8];
    wire [7:0] fuse_sel = bs2 ? (bs1 ? fuse_high_r : 8'hFF) :
                          (bs1 ? {2'h3, lock_r} : fuse_low_r);
    wire [15:0] page_word = page_buf[word_idx];
    wire [7:0] page_byte = bs1 ? page_word[15:8] : page_word[7:0];

    // read-back byte chosen by the loaded command
    always_comb begin
        unique case (cmd_r)
            CMD_RD_SIG: rd_mux = bs1 ? cal_byte : sig_byte;
            CMD_RD_FUSE: rd_mux = fuse_sel;
            CMD_RD_FLASH: rd_mux = page_byte;
            CMD_RD_EEPROM: rd_mux = page_word[7:0];
            default: rd_mux = 8'hFF;
        endcase
    end

    // busy sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (start_busy) state_nxt = ST_BUSY;
            ST_BUSY: if (busy_cnt_r == 16'h0001) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // pin history, state and busy count
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            pins_d_r <= PINS_IDLE;
            state_r <= ST_IDLE;
            busy_cnt_r <= 16'h0000;
        end else begin
            pins_d_r <= pins_q;
            state_r <= state_nxt;
            if (start_busy && idle) begin
                busy_cnt_r <= busy_load;
            end else if (busy_cnt_r != 16'h0000) begin
                busy_cnt_r <= busy_cnt_r - 16'h0001;
            end
        end
    end

    // programming mode and xtal-loaded registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            prog_mode_r <= 1'b0;
            cmd_r <= 8'h00;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            data_lo_r <= 8'h00;
            data_hi_r <= 8'h00;
        end else begin
            if (enter_prog) begin
                prog_mode_r <= 1'b1;
            end else if (leave_prog) begin
                prog_mode_r <= 1'b0;
            end
            if (prog_mode_r && xtal_rise) begin
                unique case (act)
                    ACT_ADDR: begin
                        if (bs1) addr_hi_r <= data_q;
                        else addr_lo_r <= data_q;
                    end
                    ACT_DATA: begin
                        if (bs1) data_hi_r <= data_q;
                        else data_lo_r <= data_q;
                    end
                    ACT_CMD: cmd_r <= data_q;
                    default: ;
                endcase
            end
        end
    end

    // page buffer fill on page latch strobe
    always_ff @(posedge i_mclk) begin
        if (prog_mode_r && page_latch_strobe_rise) begin
            page_buf[word_idx] <= {data_hi_r, data_lo_r};
        end
    end

    // stored fuses and locks, erase touches locks only
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            fuse_high_r <= FUSE_HIGH_RST;
            fuse_low_r <= FUSE_LOW_RST;
            lock_r <= LOCK_RST;
        end else begin
            if (do_erase) begin
                lock_r <= LOCK_RST;
            end else if (do_wr_lock) begin
                lock_r <= lock_r & data_lo_r[5:0];
            end
            if (do_wr_fuse) begin
                if (bs1) fuse_high_r <= data_lo_r;
                else fuse_low_r <= data_lo_r;
            end else if (ser_fuse_ok) begin
                if (i_ser_fuse.hi_sel) fuse_high_r <= ser_high_val;
                else fuse_low_r <= i_ser_fuse.data;
            end
        end
    end

    // active fuse copies, captured at power-up, entry and exit
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_fuse_high_act <= FUSE_HIGH_RST;
            o_fuse_low_act <= FUSE_LOW_RST;
        end else if (enter_prog || leave_prog) begin
            o_fuse_high_act <= fuse_high_r;
            o_fuse_low_act <= fuse_low_r;
        end
    end

    // eeprom preserve takes effect as soon as it is programmed
    assign o_eeprom_preserve_eff = o_fuse_high_act[FH_EEPROM_PRESERVE_FUSE] & fuse_high_r[FH_EEPROM_PRESERVE_FUSE];

    // boot section access checks
    wire store_blk = ~lock_r[LK_BOOT_LOCK_LOWER];
    wire load_blk = ~lock_r[LK_BOOT_LOCK_UPPER];
    // deny decisions for the current request
    wire store_deny_nxt = i_self_program_store_instr & i_store_target_boot &
                          store_blk;
    wire load_deny_nxt = i_program_memory_load_instr & i_load_from_app &
                         i_load_target_boot & load_blk;
    wire irq_disable_nxt = load_blk & i_exec_in_boot & i_ivec_in_app;

    // denies registered one cycle after the request
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_store_deny <= 1'b0;
            o_load_deny <= 1'b0;
            o_irq_disable <= 1'b0;
        end else begin
            o_store_deny <= store_deny_nxt;
            o_load_deny <= load_deny_nxt;
            o_irq_disable <= irq_disable_nxt;
        end
    end

    // oscillator trim: 1 MHz value at reset, software may reload
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_rc_osc_trim_register <= CAL_BYTES[7:0];
        end else if (i_trim_wr) begin
            o_rc_osc_trim_register <= i_trim_data;
        end
    end

    // read data and serial fuse readback registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            rd_data_r <= 8'hFF;
            o_ser_fuse_read <= 8'hFF;
        end else begin
            if (oe_on) rd_data_r <= rd_mux;
            o_ser_fuse_read <= i_ser_fuse.hi_sel ? (fuse_high_r | 8'h20) : fuse_low_r;
        end
    end

    // pin outputs
    assign o_data = rd_data_r;
    assign o_data_oe = oe_on;
    assign o_ready_busy_out = idle;
    assign o_prog_mode = prog_mode_r;
endmodule // fuse_prog_port

// ### verilog/pin_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for asynchronous pins
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_d,
    input wire logic [WIDTH-1:0] i_rst_val,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) $error("pin_sync width must be positive");
    end

    // first flop feeds only the second
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            meta_r <= i_rst_val;
            o_q <= i_rst_val;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule // pin_sync
